// File: logic/iem_defines.vh
/*
 interrupt enable mask: register offsets, bit positions, reset values.
 assumes inclusion by bare name from the design files.
*/
`ifndef IEM_DEFINES_VH
`define IEM_DEFINES_VH

`define IEM_ADDR_W 12
`define IEM_OFF_ENABLE 12'h000
`define IEM_OFF_PENDING 12'h004
`define IEM_OFF_GATED 12'h008

`define IEM_BIT_EXT0 0
`define IEM_BIT_TIMER0 1
`define IEM_BIT_EXT1 2
`define IEM_BIT_TIMER1 3
`define IEM_BIT_UART 4
`define IEM_BIT_TIMER2 5
`define IEM_BIT_SPI 6
`define IEM_BIT_GLOBAL 7

`define IEM_ENABLE_RESET 8'h00
`define IEM_NUM_SRC 7

`endif

// File: logic/iem_sync.v
/*
 two-flop synchroniser bank for asynchronous request levels.
 assumes one clock clk and async active-low resetn.
*/
`timescale 1ns/1ns
module iem_sync #(
	parameter WIDTH = 2
) (
	input wire clk,
	input wire resetn,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta;

// first stage feeds only the second
always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		meta <= {WIDTH{1'b0}};
		sync_out <= {WIDTH{1'b0}};
	end else begin
		meta <= async_in;
		sync_out <= meta;
	end
end

endmodule // iem_sync

// File: logic/iem_interrupt_enable_mask.v
/*
 interrupt enable mask: global enable plus seven per-source masks held in
 interrupt_enable_reg, reached over apb; gates pending source requests to the
 cpu interrupt logic.
 assumes peripheral flags come from logic on clk; the external request pins
 are asynchronous and active low; pending flags are held by their owners.
*/
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "iem_defines.vh"
module iem_interrupt_enable_mask (
	input wire clk,
	input wire resetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`IEM_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	input wire serial_periph_request,
	input wire timer2_low_overflow_flag,
	input wire timer2_high_overflow_flag,
	input wire uart_request,
	input wire timer1_overflow_flag,
	input wire timer0_overflow_flag,
	input wire external_request_pin_one_n,
	input wire external_request_pin_zero_n,
	output reg [6:0] gated_request,
	output reg any_request
);

reg [7:0] interrupt_enable_reg;
wire [1:0] ext_sync;
wire [6:0] pending;
wire [6:0] next_gated;
wire apb_write;
wire apb_read;
wire hit;

function is_mapped;
	input [`IEM_ADDR_W-1:0] addr;
	begin
		is_mapped = (addr == `IEM_OFF_ENABLE) || (addr == `IEM_OFF_PENDING) ||
			(addr == `IEM_OFF_GATED);
	end
endfunction

// external pins are not on clk; resync before any gating
// inverted ahead of the flops so their reset value matches the idle pin
iem_sync #(
	.WIDTH(2)
) u_sync (
	.clk(clk),
	.resetn(resetn),
	.async_in({~external_request_pin_one_n, ~external_request_pin_zero_n}),
	.sync_out(ext_sync)
);

// pending is never cleared here, so a blocked source waits for enable
assign pending[`IEM_BIT_EXT0] = ext_sync[0];
assign pending[`IEM_BIT_TIMER0] = timer0_overflow_flag;
assign pending[`IEM_BIT_EXT1] = ext_sync[1];
assign pending[`IEM_BIT_TIMER1] = timer1_overflow_flag;
assign pending[`IEM_BIT_UART] = uart_request;
assign pending[`IEM_BIT_TIMER2] = timer2_low_overflow_flag | timer2_high_overflow_flag;
assign pending[`IEM_BIT_SPI] = serial_periph_request;

genvar i;
generate
	for (i = 0; i < `IEM_NUM_SRC; i = i + 1) begin : g_gate
		assign next_gated[i] = pending[i] & interrupt_enable_reg[i] &
			interrupt_enable_reg[`IEM_BIT_GLOBAL];
	end
endgenerate

always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		gated_request <= 7'h00;
		any_request <= 1'b0;
	end else begin
		gated_request <= next_gated;
		any_request <= |next_gated;
	end
end

// zero-wait slave; unmapped addresses answer with an error
assign pready = 1'b1;
assign hit = is_mapped(paddr);
assign pslverr = psel & penable & ~hit;
assign apb_write = psel & penable & pwrite & hit;
assign apb_read = psel & ~penable & ~pwrite;

always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		interrupt_enable_reg <= `IEM_ENABLE_RESET;
	end else if (apb_write && paddr == `IEM_OFF_ENABLE) begin
		interrupt_enable_reg <= pwdata[7:0];
	end
end

// read data captured in setup so it is registered by the access phase
always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		prdata <= 32'h00000000;
	end else if (apb_read) begin
		case (paddr)
			`IEM_OFF_ENABLE: prdata <= {24'h000000, interrupt_enable_reg};
			`IEM_OFF_PENDING: prdata <= {25'h0, pending};
			`IEM_OFF_GATED: prdata <= {25'h0, next_gated};
			default: prdata <= 32'h00000000;
		endcase
	end
end

endmodule // iem_interrupt_enable_mask

// File: verification/iem_props.sv
/* checker for gating and register relations; sees only the top ports */
`timescale 1ns/1ns
module iem_props (
	input wire clk, resetn, psel, penable, pwrite, pready, pslverr, any_request,
	input wire serial_periph_request, timer0_overflow_flag, external_request_pin_zero_n,
	input wire [11:0] paddr,
	input wire [31:0] pwdata, prdata,
	input wire [6:0] gated_request
);
	reg [7:0] en;
	wire [6:0] m = en[7] ? en[6:0] : 7'h00;
	always @(posedge clk or negedge resetn)
		if (!resetn) en <= 8'h00;
		else if (psel && penable && pwrite && paddr == 12'h000) en <= pwdata[7:0];
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	glob_off_a: assert property (!en[7] |=> gated_request == 7'h00)
		else $error("global");
	spi_gate_a: assert property (gated_request[6] == $past(m[6] & serial_periph_request))
		else $error("spi");
	t0_gate_a: assert property (gated_request[1] == $past(m[1] & timer0_overflow_flag))
		else $error("timer0");
	ext0_gate_a: assert property ((m[0] && !external_request_pin_zero_n) [*3] |=>
		gated_request[0]) else $error("ext0");
	read_back_a: assert property (psel && penable && !pwrite && paddr == 12'h000 |->
		prdata == {24'h0, en}) else $error("readback");
	any_or_a: assert property (any_request == |gated_request)
		else $error("any");
	err_map_a: assert property (psel && penable && paddr > 12'h008 |-> pslverr) else $error("map");
	ready_high_a: assert property (psel && penable |-> pready) else $error("ready");
endmodule // iem_props
bind iem_interrupt_enable_mask iem_props props_u (.*);

// File: verification/iem_src_model.sv
/* request sources; the bench says which are pending, pins come out active low */
`timescale 1ns/1ns
module iem_src_model (
	input wire clk,
	input wire [7:0] want,
	output reg [7:0] lines = 8'h05
);
	always @(posedge clk) lines <= want ^ 8'h05;
endmodule // iem_src_model

// File: verification/testbench.sv
/* bench: apb tasks program the mask; the source model raises requests */
`timescale 1ns/1ns
module testbench;
	reg clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0, rd;
	reg err = 0;
	reg [7:0] want = 0;
	wire [7:0] s;
	wire pready, pslverr, any_request;
	wire [31:0] prdata;
	wire [6:0] gated_request;
	integer checks = 0, bad_count = 0, i, n;
	iem_src_model src_u (.clk(clk), .want(want), .lines(s));
	iem_interrupt_enable_mask dut_u (.clk(clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.gated_request(gated_request), .any_request(any_request),
		.serial_periph_request(s[6]), .uart_request(s[4]),
		.timer2_low_overflow_flag(s[5]), .timer2_high_overflow_flag(s[7]),
		.timer1_overflow_flag(s[3]), .timer0_overflow_flag(s[1]),
		.external_request_pin_one_n(s[2]), .external_request_pin_zero_n(s[0]));
	initial forever #50 clk = ~clk;
	task complete_run;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one idle edge first so psel never changes twice in one step
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk);
		if (pready !== 1'b1) bad_count++;
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task settle(input [31:0] en, input [31:0] exp);
		apb(1, 12'h000, en);
		repeat (4) @(posedge clk);
		chk({any_request, gated_request}, exp);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1;
		apb(0, 12'h000, 0);
		chk(rd, 32'h0);
		apb(0, 12'h100, 0);
		chk(rd, 32'h0);
		chk(err, 32'h1);
		apb(1, 12'h000, 32'hff);
		apb(0, 12'h000, 0);
		chk(rd, 32'hff);
		want <= 8'h7f;
		for (i = 0; i < 7; i++)
			settle(32'h80 | (1 << i), 32'h80 | (1 << i));
		settle(32'h7f, 0);
		settle(32'hff, 32'hff);
		want <= 8'h80;
		settle(32'ha0, 32'ha0);
		apb(0, 12'h004, 0);
		chk(rd, 32'h20);
		apb(0, 12'h008, 0);
		chk(rd, 32'h20);
		resetn <= 0;
		repeat (2) @(posedge clk);
		resetn <= 1;
		apb(0, 12'h000, 0);
		chk(rd, 32'h0);
		chk({any_request, gated_request}, 32'h0);
		complete_run;
	end
endmodule // testbench
